/* File: shared/counter_array_pkg.sv */
// Register map, field positions and bus states for the counter array block
// How it works
// - Modules zero to five flags set on match or capture; software alone clears.
// - Modules six and seven keep their flag in auxiliary bit three.
// - Base timer is two readable, writable bytes, high and low, reset to zero.
// - Reload high register holds the value loaded into the timer high byte.
// - Reload low register holds the value loaded into the timer low byte.
// - On sixteen-bit timer overflow both reload bytes load into the timer.
// - Mode bit zero lets a set module flag raise an interrupt request.
// - Mode bit seven enables dead time on pairs 0, 2, 4 in buffer mode.
// - Mode bit six enables the comparator; clear disables it.
// - Mode bit five captures on rising pin edge; modules six, seven never capture.
// - Mode bit four captures on falling pin edge.
// - Both capture bits set capture on either pin transition.
// - Mode bit three lets a match set the flag; clear blocks it.
// - Mode bit two toggles the module pin on each match.
// - Mode bit one drives the module pin as a pulse width output.
// - Each module has high and low value bytes for capture or compare.
// - Auxiliary register extends duty from 0% to 100% in 1/256 steps.
// - Auxiliary bits: resolution 7:6, flag 3, invert 2, ninth bits 1:0.
// - Resolution field 00, 01, 10, 11 selects 8, 10, 12, 16 bits.
// - Invert bit drives the inverted compare or pulse result on the pin.
// - Ninth bits extend the high and low value bytes in eight-bit pulse mode.
package counter_array_pkg;
  localparam int NUM_MOD = 8;
  localparam int FIRST_UP = 6;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_RLD_LO  = 8'hCE;
  localparam logic [7:0] IDX_RLD_HI  = 8'hCF;
  localparam logic [7:0] IDX_MODE6   = 8'hD0;
  localparam logic [7:0] IDX_VLO6    = 8'hD2;
  localparam logic [7:0] IDX_VHI6    = 8'hD4;
  localparam logic [7:0] IDX_AUX6    = 8'hD6;
  localparam logic [7:0] IDX_CTRL    = 8'hD8;
  localparam logic [7:0] IDX_BUFCFG  = 8'hD9;
  localparam logic [7:0] IDX_MODE0   = 8'hDA;
  localparam logic [7:0] IDX_TMR_LO  = 8'hE9;
  localparam logic [7:0] IDX_VLO0    = 8'hEA;
  localparam logic [7:0] IDX_AUX0    = 8'hF2;
  localparam logic [7:0] IDX_TMR_HI  = 8'hF9;
  localparam logic [7:0] IDX_VHI0    = 8'hFA;
  // Mode register bits
  localparam int M_IRQ = 0;
  localparam int M_PWM = 1;
  localparam int M_TOG = 2;
  localparam int M_MAT = 3;
  localparam int M_CAPN = 4;
  localparam int M_CAPP = 5;
  localparam int M_ECOM = 6;
  localparam int M_DTE = 7;
  // Auxiliary register bits
  localparam int A_LO9 = 0;
  localparam int A_HI9 = 1;
  localparam int A_INV = 2;
  localparam int A_FLAG = 3;
  localparam int A_RS = 6;
  // Control and buffer-config bits
  localparam int C_OVF = 7;
  localparam int C_RUN = 6;
  localparam int B_LSB = 4;
  localparam logic [7:0] AUX_MASK  = 8'hC7;
  localparam logic [7:0] MODE_UP   = 8'hDF;
  localparam logic [7:0] RST8      = 8'h00;
  localparam logic [15:0] TMR_TOP  = 16'hFFFF;
  localparam logic [1:0] RES_8     = 2'b00;
  localparam logic [1:0] RES_10    = 2'b01;
  localparam logic [1:0] RES_12    = 2'b10;
  localparam logic [15:0] MSK_8    = 16'h00FF;
  localparam logic [15:0] MSK_10   = 16'h03FF;
  localparam logic [15:0] MSK_12   = 16'h0FFF;
  localparam logic [23:0] RD_PAD   = 24'h000000;
  typedef enum logic [1:0] {
    BUS_IDLE    = 2'b00,
    BUS_WRITE   = 2'b01,
    BUS_RD_WAIT = 2'b10,
    BUS_RD_DONE = 2'b11
  } bus_e;
  // Index of a per-module register; upper modules sit in their own block
  function automatic logic [7:0] mod_idx(input logic [7:0] lo_base, input logic [7:0] up_base,
                                         input int n);
    return (n < FIRST_UP) ? 8'(lo_base + 8'(n)) : 8'(up_base + 8'(n - FIRST_UP));
  endfunction
  // Counter wrap mask for the chosen pulse resolution
  function automatic logic [15:0] res_mask(input logic [1:0] rs);
    return (rs == RES_8) ? MSK_8 : (rs == RES_10) ? MSK_10 : (rs == RES_12) ? MSK_12 : TMR_TOP;
  endfunction
endpackage

/* File: verilog/pin_sync.sv */
// Two-stage synchroniser for the module pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stab;
  } sync_s;
  sync_s s_q;
  sync_s s_d;

  // First stage feeds only the second
  always_comb begin
    s_d      = s_q;
    s_d.meta = din;
    s_d.stab = s_q.meta;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.stab;
endmodule

/* File: verilog/array_channel.sv */
// One compare/capture/pulse channel of the counter array
`timescale 1ns/1ps
module array_channel #(
  parameter bit HAS_CAP  = 1'b1,
  parameter bit HAS_PAIR = 1'b0,
  parameter int DEAD_CYC = 4
) (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  mode,
  input  wire logic [7:0]  aux,
  input  wire logic [7:0]  val_hi,
  input  wire logic [7:0]  val_lo,
  input  wire logic [15:0] timer,
  input  wire logic        pair_buf,
  input  wire logic        pin_in,
  output logic             match,
  output logic             capture,
  output logic             pwm_reload,
  output logic             pin_out,
  output logic             pin_oe,
  output logic             comp_hi,
  output logic             comp_lo
);
  import counter_array_pkg::*;
  typedef struct packed {
    logic       prev;
    logic       tog;
    logic       out;
    logic       oe;
    logic       hi;
    logic       lo;
    logic [3:0] dead;
  } chan_s;
  chan_s s_q;
  chan_s s_d;
  logic [15:0] mask;
  logic [16:0] cmp;
  logic        lvl;
  logic        res;

  always_comb begin
    s_d = s_q;
    match = mode[M_ECOM] && (timer == {val_hi, val_lo});
    capture = HAS_CAP && ((mode[M_CAPP] && pin_in && !s_q.prev)
                       || (mode[M_CAPN] && !pin_in && s_q.prev));
    s_d.prev = pin_in;
    // Ninth low bit set makes the count never reach: 0% duty
    mask = res_mask(aux[A_RS+:2]);
    cmp = (aux[A_RS+:2] == RES_8) ? {8'h00, aux[A_LO9], val_lo}
                                  : {1'b0, {val_hi, val_lo} & mask};
    lvl = {1'b0, timer & mask} >= cmp;
    pwm_reload = mode[M_PWM] && (aux[A_RS+:2] == RES_8) && ((timer & mask) == mask);
    if (match && mode[M_TOG]) begin
      s_d.tog = !s_q.tog;
    end
    res = mode[M_PWM] ? lvl : s_d.tog;
    s_d.out = res ^ aux[A_INV];
    s_d.oe = mode[M_PWM] || mode[M_TOG];
    // Both sides low for DEAD_CYC cycles after each edge, never overlapping
    if (HAS_PAIR && mode[M_DTE] && pair_buf) begin
      if (s_d.out != s_q.out) begin
        s_d.dead = 4'(DEAD_CYC);
      end else if (s_q.dead != 4'h0) begin
        s_d.dead = s_q.dead - 4'h1;
      end
    end else begin
      s_d.dead = 4'h0;
    end
    s_d.hi = HAS_PAIR && s_d.oe && s_d.out && (s_d.dead == 4'h0);
    s_d.lo = HAS_PAIR && s_d.oe && !s_d.out && (s_d.dead == 4'h0);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pin_out = s_q.out;
  assign pin_oe  = s_q.oe;
  assign comp_hi = s_q.hi;
  assign comp_lo = s_q.lo;
endmodule

/* File: verilog/counter_array_module_regs.sv */
// Counter array: base timer, module registers and AHB-Lite slave
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
module counter_array_module_regs #(
  parameter int DEAD_CYC = 4
) (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [7:0]  module_pin_in,
  output logic      [7:0]  module_pin_out,
  output logic      [7:0]  module_pin_oe,
  output logic      [7:0]  complementary_high_out,
  output logic      [7:0]  complementary_low_out,
  output logic      [7:0]  module_irq_req
);
  import counter_array_pkg::*;

  typedef struct packed {
    bus_e                         bus;
    logic [7:0]                   idx;
    logic [7:0]                   rdata;
    logic [15:0]                  timer;
    logic [7:0]                   rld_lo;
    logic [7:0]                   rld_hi;
    logic                         run;
    logic                         ovf;
    logic [2:0]                   bme;
    logic [NUM_MOD-1:0]           flag;
    logic [NUM_MOD-1:0][7:0]      mode;
    logic [NUM_MOD-1:0][7:0]      aux;
    logic [NUM_MOD-1:0][7:0]      vhi;
    logic [NUM_MOD-1:0][7:0]      vlo;
  } regs_s;

  regs_s              s_q;
  regs_s              s_d;
  logic [7:0]         pin_s;
  logic [NUM_MOD-1:0] match;
  logic [NUM_MOD-1:0] cap;
  logic [NUM_MOD-1:0] reload;
  logic [NUM_MOD-1:0] evt;
  logic               accept;
  logic               wr_act;
  logic               wr_ctrl;
  logic               wr_aux_up;
  logic [7:0]         wd;
  logic [7:0]         rd_val;
  logic               tmr_wrap;

  // Pins come from outside; synchronise before edge detection
  pin_sync #(
    .WIDTH (NUM_MOD)
  ) u_sync (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .din     (module_pin_in),
    .dout    (pin_s)
  );

  // One channel per module; capture only on lower six, pairs on 0, 2, 4
  for (genvar i = 0; i < NUM_MOD; i++) begin : g_ch
    array_channel #(
      .HAS_CAP  (i < FIRST_UP),
      .HAS_PAIR ((i == 0) || (i == 2) || (i == 4)),
      .DEAD_CYC (DEAD_CYC)
    ) u_ch (
      .sys_clk    (sys_clk),
      .arst_n     (arst_n),
      .mode       (s_q.mode[i]),
      .aux        (s_q.aux[i]),
      .val_hi     (s_q.vhi[i]),
      .val_lo     (s_q.vlo[i]),
      .timer      (s_q.timer),
      // Index kept in range for the upper modules, which have no buffer bit
      .pair_buf   ((i < FIRST_UP) && s_q.bme[(i < FIRST_UP) ? (i / 2) : 0]),
      .pin_in     (pin_s[i]),
      .match      (match[i]),
      .capture    (cap[i]),
      .pwm_reload (reload[i]),
      .pin_out    (module_pin_out[i]),
      .pin_oe     (module_pin_oe[i]),
      .comp_hi    (complementary_high_out[i]),
      .comp_lo    (complementary_low_out[i])
    );
  end

  // Bus handshake and decode of the latched data phase
  assign hreadyout = (s_q.bus != BUS_RD_WAIT);
  assign hresp     = 1'b0;
  assign hrdata    = {RD_PAD, s_q.rdata};
  assign accept    = hsel && htrans[1] && hready;
  assign wr_act    = (s_q.bus == BUS_WRITE);
  assign wd        = hwdata[7:0];
  assign wr_ctrl   = wr_act && (s_q.idx == IDX_CTRL);
  assign wr_aux_up = wr_act && ((s_q.idx == IDX_AUX6) || (s_q.idx == 8'(IDX_AUX6 + 8'h01)));
  assign tmr_wrap  = s_q.run && (s_q.timer == TMR_TOP);

  // Request reaches the core when enabled and the flag is up
  assign module_irq_req = s_q.flag & {s_q.mode[7][M_IRQ], s_q.mode[6][M_IRQ],
                                      s_q.mode[5][M_IRQ], s_q.mode[4][M_IRQ],
                                      s_q.mode[3][M_IRQ], s_q.mode[2][M_IRQ],
                                      s_q.mode[1][M_IRQ], s_q.mode[0][M_IRQ]};

  // Read mux; reserved bits and unmapped indices read zero
  always_comb begin
    rd_val = RST8;
    if (s_q.idx == IDX_RLD_LO) begin
      rd_val = s_q.rld_lo;
    end else if (s_q.idx == IDX_RLD_HI) begin
      rd_val = s_q.rld_hi;
    end else if (s_q.idx == IDX_TMR_LO) begin
      rd_val = s_q.timer[7:0];
    end else if (s_q.idx == IDX_TMR_HI) begin
      rd_val = s_q.timer[15:8];
    end else if (s_q.idx == IDX_CTRL) begin
      rd_val = {s_q.ovf, s_q.run, s_q.flag[5:0]};
    end else if (s_q.idx == IDX_BUFCFG) begin
      rd_val = 8'({s_q.bme, 4'h0});
    end else begin
      for (int i = 0; i < NUM_MOD; i++) begin
        if (s_q.idx == mod_idx(IDX_MODE0, IDX_MODE6, i)) begin
          rd_val = s_q.mode[i];
        end
        if (s_q.idx == mod_idx(IDX_VLO0, IDX_VLO6, i)) begin
          rd_val = s_q.vlo[i];
        end
        if (s_q.idx == mod_idx(IDX_VHI0, IDX_VHI6, i)) begin
          rd_val = s_q.vhi[i];
        end
        if (s_q.idx == mod_idx(IDX_AUX0, IDX_AUX6, i)) begin
          rd_val = s_q.aux[i];
          rd_val[A_FLAG] = (i >= FIRST_UP) && s_q.flag[i];
        end
      end
    end
  end

  // Next state: bus, timer, software writes, then hardware events
  always_comb begin
    s_d = s_q;
    evt = '0;
    // Reads wait one cycle so a write just before is seen
    if (accept && hreadyout) begin
      s_d.idx = haddr[9:2];
      s_d.bus = hwrite ? BUS_WRITE : BUS_RD_WAIT;
    end else if (s_q.bus == BUS_RD_WAIT) begin
      s_d.bus = BUS_RD_DONE;
    end else begin
      s_d.bus = BUS_IDLE;
    end
    if (s_q.bus == BUS_RD_WAIT) begin
      s_d.rdata = rd_val;
    end
    // Base timer counts every clock while running
    if (tmr_wrap) begin
      s_d.timer = {s_q.rld_hi, s_q.rld_lo};
    end else if (s_q.run) begin
      s_d.timer = s_q.timer + 16'h0001;
    end
    if (wr_act) begin
      if (s_q.idx == IDX_RLD_LO) begin
        s_d.rld_lo = wd;
      end else if (s_q.idx == IDX_RLD_HI) begin
        s_d.rld_hi = wd;
      end else if (s_q.idx == IDX_TMR_LO) begin
        s_d.timer[7:0] = wd;
      end else if (s_q.idx == IDX_TMR_HI) begin
        s_d.timer[15:8] = wd;
      end else if (s_q.idx == IDX_CTRL) begin
        s_d.ovf = wd[C_OVF];
        s_d.run = wd[C_RUN];
        s_d.flag[5:0] = wd[5:0];
      end else if (s_q.idx == IDX_BUFCFG) begin
        s_d.bme = wd[B_LSB+:3];
      end else begin
        for (int i = 0; i < NUM_MOD; i++) begin
          if (s_q.idx == mod_idx(IDX_MODE0, IDX_MODE6, i)) begin
            s_d.mode[i] = (i >= FIRST_UP) ? (wd & MODE_UP) : wd;
          end
          if (s_q.idx == mod_idx(IDX_VLO0, IDX_VLO6, i)) begin
            s_d.vlo[i] = wd;
          end
          if (s_q.idx == mod_idx(IDX_VHI0, IDX_VHI6, i)) begin
            s_d.vhi[i] = wd;
          end
          if (s_q.idx == mod_idx(IDX_AUX0, IDX_AUX6, i)) begin
            s_d.aux[i] = wd & AUX_MASK;
            if (i >= FIRST_UP) begin
              s_d.flag[i] = wd[A_FLAG];
            end
          end
        end
      end
    end
    // Hardware sets win over a software clear in the same cycle
    if (tmr_wrap) begin
      s_d.ovf = 1'b1;
    end
    for (int i = 0; i < NUM_MOD; i++) begin
      evt[i] = (match[i] && s_q.mode[i][M_MAT]) || cap[i];
      if (evt[i]) begin
        s_d.flag[i] = 1'b1;
      end
      if (cap[i]) begin
        s_d.vhi[i] = s_q.timer[15:8];
        s_d.vlo[i] = s_q.timer[7:0];
      end
      // Eight-bit pulse takes next duty from the high byte at wrap
      if (reload[i]) begin
        s_d.vlo[i] = s_q.vhi[i];
        s_d.aux[i][A_LO9] = s_q.aux[i][A_HI9];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Checks on the block's own behaviour
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  a_flag_sticky_lo: assert property (!wr_ctrl |=> (($past(s_q.flag[5:0]) & ~s_q.flag[5:0]) == 6'h00))
    else $error("low module flag cleared without a control write");
  a_flag_sticky_up: assert property (!wr_aux_up |=> (($past(s_q.flag[7:6]) & ~s_q.flag[7:6]) == 2'b00))
    else $error("upper module flag cleared without an aux write");
  a_timer_count: assert property (s_q.run && !tmr_wrap && !wr_act |=> s_q.timer == $past(s_q.timer) + 16'h0001)
    else $error("base timer did not advance by one");
  a_timer_reload: assert property (tmr_wrap && !wr_act |=> s_q.timer == {s_q.rld_hi, s_q.rld_lo} && s_q.ovf)
    else $error("base timer did not reload at overflow");
  a_irq_gate: assert property (module_irq_req[2] == (s_q.flag[2] && s_q.mode[2][M_IRQ]))
    else $error("interrupt request not flag and enable");
  a_no_upper_cap: assert property (cap[7:6] == 2'b00)
    else $error("capture seen on a module without capture");
  a_cmp_off: assert property (!s_q.mode[0][M_ECOM] |-> !match[0])
    else $error("match with comparator disabled");
  a_match_flag: assert property (match[1] && s_q.mode[1][M_MAT] |=> s_q.flag[1])
    else $error("match did not set module flag");
  a_match_equal: assert property (match[3] |-> s_q.timer == {s_q.vhi[3], s_q.vlo[3]})
    else $error("match without full timer equality");
  a_capture_copy: assert property (cap[0] |=> s_q.flag[0] && {s_q.vhi[0], s_q.vlo[0]} == $past(s_q.timer))
    else $error("capture did not copy timer with flag");
  a_read_wait: assert property (s_q.bus == BUS_RD_WAIT |-> !hreadyout ##1 hreadyout)
    else $error("read data phase not exactly one wait state");
  // Aux write in the same cycle could move the invert bit, so it is excluded
  a_toggle_pin: assert property (match[1] && s_q.mode[1][M_TOG] && !s_q.mode[1][M_PWM] && !wr_act
                                 |=> module_pin_out[1] != $past(module_pin_out[1]))
    else $error("match did not toggle the module pin");
  a_pair_split: assert property (!(complementary_high_out[0] && complementary_low_out[0]))
    else $error("both sides of an output pair driven at once");
  a_pair_odd: assert property (complementary_high_out[1] == 1'b0 && complementary_low_out[1] == 1'b0)
    else $error("pair output driven on a module without a pair");
  a_pwm_drive: assert property (s_q.mode[2][M_PWM] && !wr_act |=> module_pin_oe[2])
    else $error("pulse mode did not enable the pin drive");
  a_reload_hold: assert property (!wr_act |=> $stable(s_q.rld_lo) && $stable(s_q.rld_hi))
    else $error("reload bytes changed without a write");

  c_capture: cover property (cap[0] ##1 s_q.flag[0]);
  c_match_tog: cover property (match[1] && s_q.mode[1][M_TOG]);
  c_reload: cover property (tmr_wrap);
  c_pwm_wrap: cover property (reload[2]);
  c_dead_time: cover property (module_pin_oe[0] && !complementary_high_out[0] && !complementary_low_out[0]);
endmodule

/* File: sim/counter_array_module_regs_tb.sv */
// Self-checking bench for the counter array register block
`timescale 1ns/1ps
module counter_array_module_regs_tb;
  import counter_array_pkg::*;
  localparam int DEAD = 2;
  logic        sys_clk;
  logic        arst_n = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [7:0]  pin_in = 8'h00;
  logic [7:0]  pin_out;
  logic [7:0]  pin_oe;
  logic [7:0]  pair_hi;
  logic [7:0]  pair_lo;
  logic [7:0]  irq;
  logic [7:0]  rd;
  int          n_fail = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          reg_m[int];
  int          c;
  int          per;
  int          hi_cnt;
  int          dead_cnt;
  int          t_n[6]    = '{0, 2, 3, 6, 7, 0};
  logic [7:0]  t_aux[6]  = '{8'h00, 8'h04, 8'h40, 8'h80, 8'hC0, 8'h03};
  logic [7:0]  t_mode[6] = '{8'hC2, 8'h42, 8'h42, 8'h42, 8'h42, 8'hC2};
  logic [7:0]  t_cap[3]  = '{8'h21, 8'h11, 8'h31};
  logic [7:0]  t_rst[8]  = '{IDX_RLD_LO, IDX_RLD_HI, IDX_TMR_LO, IDX_TMR_HI, IDX_MODE0, IDX_AUX0, IDX_VLO0, IDX_VHI0};

  // Single slave, so its ready is the bus ready
  counter_array_module_regs #(.DEAD_CYC(DEAD)) counter_array_module_regs_inst (
    .sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .module_pin_in(pin_in), .module_pin_out(pin_out),
    .module_pin_oe(pin_oe), .complementary_high_out(pair_hi), .complementary_low_out(pair_lo),
    .module_irq_req(irq));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Hang guard: well above the longest expected run
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 50000) begin
      n_fail = n_fail + 1;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bounded wait for ready; sampled before the edge's own updates land
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    if (k >= 20) chk(hreadyout, 1'b1);
  endtask

  // One single word transfer; byte address is four times the index
  task automatic bus(input logic wr_en, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr_en;
    haddr <= {22'h0, idx, 2'b00};
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    wait_rdy();
    rd = hrdata[7:0];
    if (wr_en) reg_m[idx] = wd;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask

  // Per-module register index; modules six and seven sit in their own block
  function automatic logic [7:0] mi(input logic [7:0] lo, input logic [7:0] up, input int n);
    return (n < 6) ? 8'(lo + n) : 8'(up + n - 6);
  endfunction

  // Mode cleared first so a stale match cannot re-set the flag while it is cleared
  task automatic arm(input int n, input logic [7:0] mode, input logic [15:0] cv, input logic [15:0] t0);
    wr(mi(IDX_MODE0, IDX_MODE6, n), 8'h00);
    wr(IDX_CTRL, 8'h00);
    wr(mi(IDX_AUX0, IDX_AUX6, n), 8'h00);
    wr(IDX_TMR_HI, t0[15:8]);
    wr(IDX_TMR_LO, t0[7:0]);
    wr(mi(IDX_VHI0, IDX_VHI6, n), cv[15:8]);
    wr(mi(IDX_VLO0, IDX_VLO6, n), cv[7:0]);
    wr(mi(IDX_MODE0, IDX_MODE6, n), mode);
    wr(IDX_CTRL, 8'h40);
    repeat (30) @(posedge sys_clk);
  endtask

  // Timer starts at the reload point so the first period is already a full one
  task automatic pwm_run(input int n, input logic [7:0] aux, input logic [7:0] mode, input logic [15:0] cv,
                         input logic [7:0] rh);
    wr(IDX_CTRL, 8'h00);
    wr(IDX_RLD_HI, rh);
    wr(IDX_RLD_LO, 8'h00);
    wr(IDX_TMR_HI, rh);
    wr(IDX_TMR_LO, 8'h00);
    wr(mi(IDX_VLO0, IDX_VLO6, n), cv[7:0]);
    wr(mi(IDX_VHI0, IDX_VHI6, n), (aux[7:6] == 2'b00) ? cv[7:0] : cv[15:8]);
    wr(mi(IDX_AUX0, IDX_AUX6, n), aux);
    wr(mi(IDX_MODE0, IDX_MODE6, n), mode);
    wr(IDX_CTRL, 8'h40);
    repeat (300) @(posedge sys_clk);
  endtask

  initial begin
    c = $urandom(30736);
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    // Reset values, then random read-back with the timer stopped
    foreach (t_rst[i]) rdc(t_rst[i], RST8);
    foreach (t_rst[i]) begin
      // Pulse bit kept off: a stopped timer at FF would keep reloading value low
      wr(t_rst[i], 8'($urandom) & ((t_rst[i] == IDX_MODE0) ? 8'hFD : 8'hFF));
      rdc(t_rst[i], 8'(reg_m[t_rst[i]]) & ((t_rst[i] == IDX_AUX0) ? AUX_MASK : 8'hFF));
    end
    wr(IDX_MODE0, 8'h00);
    wr(IDX_MODE6, 8'hFF);
    rdc(IDX_MODE6, MODE_UP);
    wr(IDX_MODE6, 8'h00);
    wr(8'h10, 8'hFF);
    rdc(8'h10, 8'h00);
    // Overflow reloads both bytes, so the high byte never leaves FF
    wr(IDX_RLD_HI, 8'hFF);
    wr(IDX_RLD_LO, 8'h00);
    wr(IDX_TMR_HI, 8'hFF);
    wr(IDX_TMR_LO, 8'hF0);
    wr(IDX_CTRL, 8'h40);
    repeat (400) @(posedge sys_clk);
    rdc(IDX_TMR_HI, 8'hFF);
    rdc(IDX_CTRL, 8'hC0);
    // Match sets the flag only with comparator and match enable both on
    for (int n = 0; n < 8; n++) begin
      c = 16'h0100 + $urandom % 16'hE000;
      arm(n, 8'h49, 16'(c), 16'(c - 4));
      chk(irq, 8'h01 << n);
      if (n < 6) rdc(IDX_CTRL, 8'h40 | (8'h01 << n));
      else rdc(mi(IDX_AUX0, IDX_AUX6, n), 8'h08);
      arm(n, 8'h41, 16'(c), 16'(c - 4));
      chk(irq, 8'h00);
      arm(n, 8'h09, 16'(c), 16'(c - 4));
      chk(irq, 8'h00);
    end
    // Each match flips the pin once
    arm(1, 8'h44, 16'(c), 16'(c - 4));
    chk({pin_oe[1], pin_out[1]}, 2'b11);
    arm(1, 8'h44, 16'(c), 16'(c - 4));
    chk(pin_out[1], 1'b0);
    // Capture on rising, falling and either edge with the timer frozen
    for (int n = 0; n < 6; n++) begin
      c = $urandom % 32'h10000;
      wr(mi(IDX_MODE0, IDX_MODE6, n), 8'h00);
      wr(IDX_CTRL, 8'h00);
      pin_in[n] <= (n % 3 != 0);
      wr(IDX_TMR_HI, c[15:8]);
      wr(IDX_TMR_LO, c[7:0]);
      wr(mi(IDX_MODE0, IDX_MODE6, n), t_cap[n % 3]);
      pin_in[n] <= (n % 3 == 0);
      repeat (8) @(posedge sys_clk);
      chk(irq[n], 1'b1);
      rdc(mi(IDX_VHI0, IDX_VHI6, n), c[15:8]);
      rdc(mi(IDX_VLO0, IDX_VLO6, n), c[7:0]);
    end
    // Duty cycle over one whole period per resolution; dead time on pair 0/1 only
    wr(IDX_BUFCFG, 8'h10);
    for (int i = 0; i < 6; i++) begin
      per = (i == 4) ? 4096 : 256 << (2 * t_aux[i][7:6]);
      c = 16 + $urandom % (per - 32);
      if (i == 4) c = c + 16'hF000;
      pwm_run(t_n[i], t_aux[i], t_mode[i], 16'(c), (i == 4) ? 8'hF0 : 8'h00);
      hi_cnt = 0;
      dead_cnt = 0;
      repeat (per) begin
        @(negedge sys_clk);
        hi_cnt += (pin_out[t_n[i]] === 1'b1);
        dead_cnt += (pair_hi[t_n[i]] === 1'b0 && pair_lo[t_n[i]] === 1'b0);
      end
      chk(pin_oe[t_n[i]], 1'b1);
      chk(hi_cnt, (i == 5) ? 0 : t_aux[i][2] ? c % per : per - c % per);
      chk(dead_cnt, (i == 0) ? 2 * DEAD : (t_n[i] < 3) ? 0 : per);
    end
    wrap_up();
  end
endmodule
